// ===== inc/param_slave_params.svh
// constants of the serial parameter slave: timing, framing and address map
`ifndef PARAM_SLAVE_PARAMS_SVH
`define PARAM_SLAVE_PARAMS_SVH
`define CLK_HZ 20000000
`define BAUD_RATE 9600
`define BIT_CYC (`CLK_HZ / `BAUD_RATE)
`define GAP_MS 50
`define GAP_CYC (`GAP_MS * (`CLK_HZ / 1000))
`define PRM_BASE 16'h8000
`define PRM_TOP 16'hBFFF
`define BLK_STRIDE 32
`define PRM_STRIDE 4
`define PRM_PER_BLK 4
`define FC_READ 8'h03
`define FC_WRITE 8'h10
`define WORD_QTY 16'h0002
`define BYTE_CNT 8'h04
`define CNT_MAX 32'h05F5E0FF
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define FRAME_MAX 13
`define RD_REQ_LEN 4'hD
`define RD_REQ_N 4'h8
`define WR_REQ_N 4'hD
`define RD_RSP_N 4'h7
`define WR_RSP_N 4'h6
`endif

// ===== inc/param_slave_pkg.sv
// types shared by the serial parameter slave
`default_nettype none
package param_slave_pkg;
  typedef enum logic [2:0] {
    ST_RX   = 3'h1,
    ST_EXEC = 3'h2,
    ST_TX   = 3'h4
  } st_t;

  // fields of a received request, most significant byte first
  typedef struct packed {
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] start;
    logic [15:0] qty;
    logic [7:0] bcnt;
    logic [31:0] value;
  } req_t;
endpackage
`default_nettype wire

// ===== hw/block_param_modbus_slave.sv
// serial slave that reads and writes 32-bit function block parameters
//
// What this block does
// - address is base plus block*32 plus param*4
// - one parameter is two 16-bit words
// - read request: address, 03, start, 0002, crc
// - read reply: address, 03, 04, value, crc
// - write request carries 0002, 04, value, crc
// - write reply echoes start and count, crc
// - on-delay times held as plain milliseconds
// - counter preset plain binary, at most 99999999
// - analog monitor has four parameters, four apart
// - analog set values stored and returned times 100
// - block numbers count from zero
// - line runs 9600 baud, 8 data, 1 stop
// - 50 ms idle gap ends a frame
`timescale 1ns/1ps
`include "param_slave_params.svh"
`default_nettype none
module block_param_modbus_slave #(
  parameter int unsigned BIT_CYC = `BIT_CYC,
  parameter int unsigned GAP_CYC = `GAP_CYC,
  parameter int unsigned NUM_BLOCKS = 64,
  localparam int IW = $clog2(NUM_BLOCKS * `PRM_PER_BLK)
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic rx_in,
  input wire logic [7:0] slave_addr_in,
  input wire logic [IW-1:0] prm_idx_in,
  output logic tx_out,
  output logic [31:0] prm_data_out,
  output logic wr_done_out
);
  // crc-16 update for one byte, lsb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // input synchroniser and line receiver
  logic [2:0] sync_reg, sync_next;
  logic rx_lvl_reg, rx_lvl_next;
  logic rx_act_reg, rx_act_next;
  logic [15:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [23:0] gap_reg, gap_next;
  logic rx_stb;
  logic frame_end;

  // a level change counts only once stages two and three agree
  always_comb begin
    sync_next = {sync_reg[1:0], rx_in};
    rx_lvl_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : rx_lvl_reg;
    rx_act_next = rx_act_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_stb = 1'b0;
    if (!rx_act_reg) begin
      if (!rx_lvl_reg) begin
        rx_act_next = 1'b1; // start edge, sample mid bit
        rx_cnt_next = 16'(BIT_CYC / 2);
        rx_bit_next = 4'h0;
      end
    end else if (rx_cnt_reg != 16'h0000) begin
      rx_cnt_next = rx_cnt_reg - 16'h0001;
    end else begin
      rx_cnt_next = 16'(BIT_CYC - 1);
      rx_bit_next = rx_bit_reg + 4'h1;
      if (rx_bit_reg == 4'h0) begin
        if (rx_lvl_reg) begin
          rx_act_next = 1'b0; // glitch, not a start bit
        end
      end else if (rx_bit_reg < 4'h9) begin
        rx_sh_next = {rx_lvl_reg, rx_sh_reg[7:1]};
      end else begin
        rx_act_next = 1'b0;
        rx_stb = rx_lvl_reg; // framing error drops the byte
      end
    end
    // idle time counter saturates at the gap length
    if (rx_act_reg || !rx_lvl_reg) begin
      gap_next = 24'h000000;
    end else if (gap_reg != 24'(GAP_CYC)) begin
      gap_next = gap_reg + 24'h000001;
    end else begin
      gap_next = gap_reg;
    end
    frame_end = !rx_act_reg && rx_lvl_reg &&
                gap_reg == 24'(GAP_CYC - 1);
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_reg <= 3'h7;
      rx_lvl_reg <= 1'b1;
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      gap_reg <= 24'h000000;
    end else begin
      sync_reg <= sync_next;
      rx_lvl_reg <= rx_lvl_next;
      rx_act_reg <= rx_act_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      gap_reg <= gap_next;
    end
  end

  // frame handling, decode and reply
  param_slave_pkg::st_t st_reg, st_next;
  logic [7:0] buf_reg [`FRAME_MAX];
  logic [7:0] buf_next [`FRAME_MAX];
  logic [3:0] n_reg, n_next;
  logic ovf_reg, ovf_next;
  logic [15:0] crc_reg, crc_next;
  logic [3:0] len_reg, len_next;
  logic [3:0] tx_idx_reg, tx_idx_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [15:0] tx_cnt_reg, tx_cnt_next;
  logic [8:0] tx_sh_reg, tx_sh_next;
  logic tx_reg, tx_next;
  logic wr_done_reg;
  logic [31:0] prm_mem [NUM_BLOCKS * `PRM_PER_BLK];
  param_slave_pkg::req_t req;
  logic [15:0] off;
  logic [IW-1:0] idx;
  logic addr_ok, good, is_wr, mem_we;
  logic [7:0] tx_byte;
  logic [31:0] rd_val;

  // request fields and address decode
  always_comb begin
    req = {buf_reg[0], buf_reg[1], buf_reg[2], buf_reg[3], buf_reg[4],
           buf_reg[5], buf_reg[6], buf_reg[7], buf_reg[8], buf_reg[9],
           buf_reg[10]};
    off = req.start - `PRM_BASE;
    idx = IW'({off[13:5], off[3:2]});
    // parameter numbers 0..3 only, on four-unit steps
    addr_ok = req.start >= `PRM_BASE && req.start <= `PRM_TOP &&
              off[1:0] == 2'h0 && off[4] == 1'b0 &&
              32'(off[13:5]) < NUM_BLOCKS;
    is_wr = req.func == `FC_WRITE;
    // values are kept raw: ms times, binary counts, scaled analog
    good = !ovf_reg && crc_reg == 16'h0000 &&
           req.slave == slave_addr_in &&
           addr_ok && req.qty == `WORD_QTY &&
           ((req.func == `FC_READ && n_reg == `RD_REQ_N) ||
            (is_wr && n_reg == `WR_REQ_N && req.bcnt == `BYTE_CNT &&
             req.value <= `CNT_MAX));
    rd_val = prm_mem[idx];
    mem_we = st_reg == param_slave_pkg::ST_EXEC && good && is_wr;
  end

  always_comb begin
    st_next = st_reg;
    buf_next = buf_reg;
    n_next = n_reg;
    ovf_next = ovf_reg;
    crc_next = crc_reg;
    len_next = len_reg;
    tx_idx_next = tx_idx_reg;
    tx_bit_next = tx_bit_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_sh_next = tx_sh_reg;
    tx_next = tx_reg;
    tx_byte = (tx_idx_reg < len_reg) ? buf_reg[tx_idx_reg] :
              (tx_idx_reg == len_reg) ? crc_reg[7:0] : crc_reg[15:8];
    unique case (st_reg)
      param_slave_pkg::ST_RX: begin
        if (rx_stb) begin
          // running crc over every byte, so a good frame leaves zero
          crc_next = crc_byte(crc_reg, rx_sh_reg);
          if (n_reg < 4'(`FRAME_MAX)) begin
            buf_next[n_reg] = rx_sh_reg;
            n_next = n_reg + 4'h1;
          end else begin
            ovf_next = 1'b1;
          end
        end else if (frame_end && (n_reg != 4'h0 || ovf_reg)) begin
          st_next = param_slave_pkg::ST_EXEC;
        end
      end
      param_slave_pkg::ST_EXEC: begin
        n_next = 4'h0;
        ovf_next = 1'b0;
        crc_next = `CRC_INIT;
        if (!good) begin
          st_next = param_slave_pkg::ST_RX;
        end else begin
          st_next = param_slave_pkg::ST_TX;
          tx_idx_next = 4'h0;
          tx_bit_next = 4'h0;
          tx_cnt_next = 16'h0000;
          if (is_wr) begin
            len_next = `WR_RSP_N;
          end else begin
            len_next = `RD_RSP_N;
            buf_next[2] = `BYTE_CNT;
            buf_next[3] = rd_val[31:24];
            buf_next[4] = rd_val[23:16];
            buf_next[5] = rd_val[15:8];
            buf_next[6] = rd_val[7:0];
          end
        end
      end
      param_slave_pkg::ST_TX: begin
        if (tx_cnt_reg != 16'h0000) begin
          tx_cnt_next = tx_cnt_reg - 16'h0001;
        end else if (tx_bit_reg == 4'h0) begin
          if (tx_idx_reg > len_reg + 4'h1) begin
            st_next = param_slave_pkg::ST_RX;
            crc_next = `CRC_INIT;
          end else begin
            // crc is appended low byte first, then high byte
            if (tx_idx_reg < len_reg) begin
              crc_next = crc_byte(crc_reg, tx_byte);
            end
            tx_sh_next = {1'b1, tx_byte};
            tx_next = 1'b0;
            tx_idx_next = tx_idx_reg + 4'h1;
            tx_bit_next = 4'h1;
            tx_cnt_next = 16'(BIT_CYC - 1);
          end
        end else if (tx_bit_reg < 4'hA) begin
          tx_next = tx_sh_reg[0];
          tx_sh_next = {1'b1, tx_sh_reg[8:1]};
          tx_bit_next = tx_bit_reg + 4'h1;
          tx_cnt_next = 16'(BIT_CYC - 1);
        end else begin
          tx_bit_next = 4'h0; // stop bit finished
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= param_slave_pkg::ST_RX;
      for (int i = 0; i < `FRAME_MAX; i++) begin
        buf_reg[i] <= 8'h00;
      end
      n_reg <= 4'h0;
      ovf_reg <= 1'b0;
      crc_reg <= `CRC_INIT;
      len_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_cnt_reg <= 16'h0000;
      tx_sh_reg <= 9'h1FF;
      tx_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      buf_reg <= buf_next;
      n_reg <= n_next;
      ovf_reg <= ovf_next;
      crc_reg <= crc_next;
      len_reg <= len_next;
      tx_idx_reg <= tx_idx_next;
      tx_bit_reg <= tx_bit_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_sh_reg <= tx_sh_next;
      tx_reg <= tx_next;
    end
  end

  // parameter store; reset clears it so reads are never undefined
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NUM_BLOCKS * `PRM_PER_BLK; i++) begin
        prm_mem[i] <= 32'h00000000;
      end
      prm_data_out <= 32'h00000000;
      wr_done_reg <= 1'b0;
    end else begin
      if (mem_we) begin
        prm_mem[idx] <= req.value;
      end
      prm_data_out <= prm_mem[prm_idx_in];
      wr_done_reg <= mem_we;
    end
  end

  assign tx_out = tx_reg;
  assign wr_done_out = wr_done_reg;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  idle_line_a: assert property (
    st_reg == param_slave_pkg::ST_RX |-> tx_reg)
    else $error("line not idle outside a reply");
  start_in_tx_a: assert property (
    $fell(tx_reg) |-> st_reg == param_slave_pkg::ST_TX)
    else $error("start bit outside a reply");
  exec_once_a: assert property (
    st_reg == param_slave_pkg::ST_EXEC |=>
    st_reg != param_slave_pkg::ST_EXEC)
    else $error("decode state held");
  crc_drop_a: assert property (
    st_reg == param_slave_pkg::ST_EXEC && crc_reg != 16'h0000 |=>
    st_reg == param_slave_pkg::ST_RX ##1 tx_reg [*8])
    else $error("bad crc frame answered");
  addr_drop_a: assert property (
    st_reg == param_slave_pkg::ST_EXEC && req.slave != slave_addr_in |=>
    st_reg == param_slave_pkg::ST_RX)
    else $error("foreign frame answered");
  wr_max_a: assert property (
    mem_we |-> {buf_reg[7], buf_reg[8], buf_reg[9], buf_reg[10]} <=
    `CNT_MAX && buf_reg[6] == `BYTE_CNT)
    else $error("write above preset limit accepted");
  wr_map_a: assert property (
    mem_we |-> `PRM_BASE + 16'(idx[IW-1:2]) * 16'(`BLK_STRIDE) +
    16'(idx[1:0]) * 16'(`PRM_STRIDE) == req.start)
    else $error("parameter index does not match address");
  wr_store_a: assert property (
    mem_we |=> prm_mem[$past(idx)] == $past(req.value) && wr_done_out)
    else $error("accepted value not stored");
  rd_reply_a: assert property (
    st_reg == param_slave_pkg::ST_EXEC && good && !is_wr |=>
    len_reg == `RD_RSP_N && buf_reg[2] == `BYTE_CNT &&
    st_reg == param_slave_pkg::ST_TX)
    else $error("read reply malformed");
  wr_echo_a: assert property (
    mem_we |=> len_reg == `WR_RSP_N && st_reg == param_slave_pkg::ST_TX)
    else $error("write echo malformed");
  gap_end_a: assert property (
    st_reg == param_slave_pkg::ST_RX && frame_end && !rx_stb &&
    n_reg != 4'h0 |=> st_reg == param_slave_pkg::ST_EXEC)
    else $error("gap did not close the frame");
endmodule // block_param_modbus_slave
`default_nettype wire

// ===== tb/serial_master_model.sv
// serial master model: sends rtu requests and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module serial_master_model #(
  parameter int unsigned BIT_CYC = 16
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] rx_q [$];

  // crc-16 over a byte queue, reflected, preset to all ones
  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // whole frame, check low byte first; bad flips one check bit
  task automatic send_frame(input logic [7:0] b [$], input logic bad);
    logic [15:0] c;
    logic [9:0] sh;
    c = crc16(b) ^ {15'h0000, bad};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    foreach (b[i]) begin
      sh = {1'b1, b[i], 1'b0};
      for (int k = 0; k < 10; k++) begin
        @(posedge clk_in);
        #1 line_out = sh[k];
        repeat (BIT_CYC - 1) @(posedge clk_in);
      end
    end
  endtask

  // line idles high between frames, which also gives the idle gap
  initial begin
    line_out = 1'b1;
  end

  // reply collector resyncs on each start bit and samples mid-bit
  initial begin
    logic [7:0] d;
    forever begin
      @(negedge line_in);
      repeat (BIT_CYC / 2) @(posedge clk_in);
      for (int k = 0; k < 8; k++) begin
        repeat (BIT_CYC) @(posedge clk_in);
        d[k] = line_in;
      end
      repeat (BIT_CYC) @(posedge clk_in);
      if (line_in === 1'b1) begin
        rx_q.push_back(d);
      end
    end
  end
endmodule // serial_master_model
`default_nettype wire

// ===== tb/block_param_modbus_slave_tb_top.sv
// testbench for the serial parameter slave
`timescale 1ns/1ps
`default_nettype none
module block_param_modbus_slave_tb_top;
  typedef logic [7:0] byte_q_t [$];
  logic ref_clk_in;
  logic nrst_in;
  logic rx_line;
  logic tx_line;
  logic wr_done;
  logic [7:0] prm_idx;
  logic [31:0] prm_data;
  logic [7:0] slave_addr;
  int miscompares;
  int checked;
  int done_cnt;

  block_param_modbus_slave #(.BIT_CYC(16), .GAP_CYC(200))
    u_block_param_modbus_slave (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .rx_in(rx_line),
    .slave_addr_in(slave_addr), .prm_idx_in(prm_idx), .tx_out(tx_line),
    .prm_data_out(prm_data), .wr_done_out(wr_done));
  serial_master_model #(.BIT_CYC(16)) u_serial_master_model (
    .clk_in(ref_clk_in), .line_in(tx_line), .line_out(rx_line));

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // count store pulses so refused frames can be told apart
  always @(posedge ref_clk_in) begin
    if (wr_done === 1'b1) begin
      done_cnt++;
    end
  end

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  function automatic byte_q_t rd_req(logic [7:0] a, logic [15:0] s,
                                     logic [7:0] q);
    return '{a, 8'h03, s[15:8], s[7:0], 8'h00, q};
  endfunction

  function automatic byte_q_t wr_req(logic [7:0] a, logic [15:0] s,
                                     logic [31:0] v);
    return '{a, 8'h10, s[15:8], s[7:0], 8'h00, 8'h02, 8'h04,
             v[31:24], v[23:16], v[15:8], v[7:0]};
  endfunction

  // send one request, then compare the reply (empty: none allowed)
  task automatic transact(input byte_q_t req, input logic bad,
                          input byte_q_t exp);
    logic [15:0] c;
    int n;
    u_serial_master_model.rx_q.delete();
    u_serial_master_model.send_frame(req, bad);
    if (exp.size() > 0) begin
      c = u_serial_master_model.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    n = 0;
    while ((exp.size() == 0 || u_serial_master_model.rx_q.size() <
            exp.size()) && n < 2500) begin
      @(posedge ref_clk_in);
      n++;
    end
    if (exp.size() > 0 && n >= 2500) begin
      check(1'b0, "reply timeout");
      print_verdict();
    end
    repeat (200) @(posedge ref_clk_in);
    check(u_serial_master_model.rx_q.size() == exp.size(), "reply length");
    foreach (exp[i]) begin
      if (i < u_serial_master_model.rx_q.size()) begin
        check(u_serial_master_model.rx_q[i] === exp[i], "reply byte");
      end
    end
  endtask

  task automatic test_time_param();
    int d0;
    d0 = done_cnt;
    check(u_serial_master_model.crc16('{8'h01, 8'h03, 8'h04, 8'h00, 8'h00,
          8'h03, 8'hE8}) === 16'h8DFA, "check code of model");
    transact(wr_req(8'h01, 16'h8000, 32'h00030D40), 1'b0,
             '{8'h01, 8'h10, 8'h80, 8'h00, 8'h00, 8'h02});
    check(done_cnt == d0 + 1, "one store pulse");
    transact(rd_req(8'h01, 16'h8000, 8'h02), 1'b0,
             '{8'h01, 8'h03, 8'h04, 8'h00, 8'h03, 8'h0D, 8'h40});
    transact(wr_req(8'h01, 16'h8000, 32'h000003E8), 1'b0,
             '{8'h01, 8'h10, 8'h80, 8'h00, 8'h00, 8'h02});
    transact(rd_req(8'h01, 16'h8000, 8'h02), 1'b0,
             '{8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h03, 8'hE8});
    $display("test time_param done");
  endtask

  task automatic test_counter_limit();
    int d0;
    transact(wr_req(8'h01, 16'h80AC, 32'h05F5E0FF), 1'b0,
             '{8'h01, 8'h10, 8'h80, 8'hAC, 8'h00, 8'h02});
    #1 prm_idx = 8'h17;
    repeat (2) @(posedge ref_clk_in);
    check(prm_data === 32'h05F5E0FF, "block 5 param 3 value");
    d0 = done_cnt;
    transact(wr_req(8'h01, 16'h80AC, 32'h05F5E100), 1'b0, '{});
    check(done_cnt == d0, "over-limit value stored");
    check(prm_data === 32'h05F5E0FF, "over-limit value changed");
    $display("test counter_limit done");
  endtask

  task automatic test_analog();
    transact(wr_req(8'h01, 16'h80A0, 32'h00000064), 1'b0,
             '{8'h01, 8'h10, 8'h80, 8'hA0, 8'h00, 8'h02});
    transact(rd_req(8'h01, 16'h80A0, 8'h02), 1'b0,
             '{8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h64});
    transact(rd_req(8'h01, 16'h80A4, 8'h02), 1'b0,
             '{8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("test analog done");
  endtask

  task automatic test_refused();
    int d0;
    d0 = done_cnt;
    transact(wr_req(8'h01, 16'h8020, 32'h00000005), 1'b1, '{});
    transact(wr_req(8'h02, 16'h8020, 32'h00000005), 1'b0, '{});
    transact(wr_req(8'h01, 16'h8010, 32'h00000005), 1'b0, '{});
    transact(rd_req(8'h01, 16'h8000, 8'h01), 1'b0, '{});
    transact('{8'h01, 8'h06, 8'h80, 8'h20, 8'h00, 8'h05}, 1'b0, '{});
    transact(rd_req(8'h01, 16'h7FFC, 8'h02), 1'b0, '{});
    // fourteen bytes overrun the buffer, so the frame must be dropped
    transact('{8'h01, 8'h10, 8'h80, 8'h20, 8'h00, 8'h02, 8'h04, 8'h00,
               8'h00, 8'h00, 8'h05, 8'h00}, 1'b0, '{});
    check(done_cnt == d0, "refused frame stored");
    #1 prm_idx = 8'h04;
    repeat (2) @(posedge ref_clk_in);
    check(prm_data === 32'h00000000, "block 1 param 0 changed");
    // own address follows the strap, not a fixed value
    #1 slave_addr = 8'h02;
    transact(rd_req(8'h02, 16'h8000, 8'h02), 1'b0,
             '{8'h02, 8'h03, 8'h04, 8'h00, 8'h00, 8'h03, 8'hE8});
    transact(rd_req(8'h01, 16'h8000, 8'h02), 1'b0, '{});
    $display("test refused done");
  endtask

  initial begin
    miscompares = 0;
    checked = 0;
    slave_addr = 8'h01;
    prm_idx = 8'h00;
    nrst_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 nrst_in = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    test_time_param();
    test_counter_limit();
    test_analog();
    test_refused();
    print_verdict();
  end
endmodule // block_param_modbus_slave_tb_top
`default_nettype wire
